// [hw/tas_regs.sv]
/*
 * Register bank, status flags, alert latch and over-temperature comparators of a dual-channel
 * temperature monitor.
 * Assumes a bus engine presents byte accesses at register addresses on the system clock, and
 * a converter delivers raw results with a one-cycle done pulse.
 */
// Notes on behaviour
// - Status at 0x02 is read only; writes leave flags untouched.
// - Status bit 7 is high while a conversion runs.
// - Alert mode: local high sets bit 6, local low sets bit 5.
// - Alert mode: remote high sets bit 4, remote low sets bit 3.
// - Remote open circuit sets bit 2.
// - Alert mode: any of bits 6..2 high sets the alert latch and drives alert low unless setup bit 7 masks it.
// - Status read clears bits 6..2 only where the cause has gone.
// - Alert latch clears on alert-response read with cause gone and flags clear.
// - Bit 1 is remote over-temperature trip, bit 0 local trip.
// - Over-temperature output low while bit 1 or 0 set; clears itself.
// - Over-temperature releases at limit minus hysteresis from 0x21.
// - Second comparator mode: pin low on bits 6 or 4, like the primary.
// - Alert mode flags latch until read; comparator mode latches only bit 2.
// - Remote offset is ten-bit signed across 0x11 and top bits of 0x12.
// - Offset in quarter degrees is added to each remote result.
// - Offset registers power up at zero.
// - Any write to 0x0F starts one conversion; data discarded.
// - Bits 3:1 of 0x22 set consecutive faults needed: one to four.
// - Bit 7 of 0x22 enables a 25 ms bus idle timeout, off at power-up.
// - Local high limit read 0x05 write 0x0B; low read 0x06 write 0x0C.
// - Remote high limit read 0x07 write 0x0D, reset 0x55; low 0x08/0x0E.
// - Setup bit 5 selects alert pin or second comparator function.
// - High limit trips on greater-than, low limit on less-or-equal.
// - Alert-response read is answered while alert is low; it clears the latch only with cause gone and flags clear.
`timescale 1ns/1ps
`default_nettype none
module tas_regs #(
	parameter int TIMEOUT_CYCLES = tas_pkg::TIMEOUT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic i_ara_read,
	input wire logic i_bus_in_txn,
	input wire logic i_bus_active,
	output logic o_bus_abort,
	input wire logic i_conv_busy,
	input wire logic i_conv_done,
	input wire logic [7:0] i_local_raw,
	input wire logic [9:0] i_remote_raw,
	input wire logic i_remote_open,
	output logic o_conv_start,
	output logic o_standby,
	output logic [3:0] o_rate_code,
	output logic o_ext_range,
	output logic o_ara_answer,
	output logic o_alert_n_oe,
	output logic o_overtemp_comparator_out_n
);
	typedef struct packed {
		logic [7:0] setup;
		logic [7:0] rate;
		logic [7:0] loc_up;
		logic [7:0] loc_lo;
		logic [7:0] rem_up_hi;
		logic [7:0] rem_lo_hi;
		logic [7:0] rem_up_lo;
		logic [7:0] rem_lo_lo;
		logic [7:0] corr_hi;
		logic [7:0] corr_lo;
		logic [7:0] rem_ot;
		logic [7:0] loc_ot;
		logic [7:0] hyst;
		logic [7:0] fcnt;
		logic [7:0] local_temp;
		logic [9:0] remote_temp;
		logic [6:0] flags;
		logic busy;
		logic alert_latch;
		logic loc_ot_trip;
		logic rem_ot_trip;
		logic loc_up_trip;
		logic rem_up_trip;
		logic [7:0] rdata;
		logic conv_start;
		logic alert_oe;
		logic ot_n;
		logic ara_ans;
	} tas_regs_t;
	tas_regs_t st_ff;
	tas_regs_t nxt_st;

	logic comp_mode;
	logic [9:0] corr;
	logic [9:0] rem_adj;
	logic [9:0] rem_up;
	logic [9:0] rem_lo;
	logic [3:0] cond;
	logic [3:0] fire;
	logic [7:0] flag_rd;
	logic [4:0] cause;
	logic [7:0] loc_rel;
	logic [7:0] rem_rel;
	logic wd_abort;
	logic open_s1_ff;
	logic open_s2_ff;

	assign comp_mode = st_ff.setup[tas_pkg::SETUP_PIN_MODE_BIT];
	assign corr = {st_ff.corr_hi, st_ff.corr_lo[7:6]};
	assign rem_adj = i_remote_raw + corr;
	assign rem_up = {st_ff.rem_up_hi, st_ff.rem_up_lo[7:6]};
	assign rem_lo = {st_ff.rem_lo_hi, st_ff.rem_lo_lo[7:6]};
	// Limits compare against the fresh results; quarter-degree bits are in the remote fields.
	assign cond[0] = i_local_raw > st_ff.loc_up;
	assign cond[1] = i_local_raw <= st_ff.loc_lo;
	assign cond[2] = rem_adj > rem_up;
	assign cond[3] = rem_adj <= rem_lo;
	assign loc_rel = st_ff.loc_ot - st_ff.hyst;
	assign rem_rel = st_ff.rem_ot - st_ff.hyst;
	assign flag_rd = {st_ff.busy, st_ff.flags};
	// Causes for bits 6..3 come from the stored results, since raw inputs only hold with done; bit 2 uses the synchronised open input.
	assign cause = {(st_ff.local_temp > st_ff.loc_up),
		(st_ff.local_temp <= st_ff.loc_lo),
		(st_ff.remote_temp > rem_up),
		(st_ff.remote_temp <= rem_lo),
		open_s2_ff};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_filt
			tas_run_filter u_filt (
				.i_sys_clk(i_sys_clk),
				.i_resetn(i_resetn),
				.i_sample(i_conv_done),
				.i_out(cond[g]),
				.i_need_code(st_ff.fcnt[tas_pkg::FCNT_LSB +: 3]),
				.o_fire(fire[g])
			);
		end
	endgenerate

	tas_bus_watchdog #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_wd (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_enable(st_ff.fcnt[tas_pkg::FCNT_TIMEOUT_BIT]),
		.i_in_txn(i_bus_in_txn),
		.i_active(i_bus_active),
		.o_abort(wd_abort)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.conv_start = 1'b0;
		nxt_st.busy = i_conv_busy;
		if (i_reg_rd) begin
			case (i_reg_addr)
				tas_pkg::RD_LOCAL_TEMP: nxt_st.rdata = st_ff.local_temp;
				tas_pkg::RD_REMOTE_HI: nxt_st.rdata = st_ff.remote_temp[9:2];
				tas_pkg::RD_FLAGS: nxt_st.rdata = flag_rd;
				tas_pkg::RD_SETUP: nxt_st.rdata = st_ff.setup;
				tas_pkg::RD_RATE: nxt_st.rdata = st_ff.rate;
				tas_pkg::RD_LOC_UP: nxt_st.rdata = st_ff.loc_up;
				tas_pkg::RD_LOC_LO: nxt_st.rdata = st_ff.loc_lo;
				tas_pkg::RD_REM_UP_HI: nxt_st.rdata = st_ff.rem_up_hi;
				tas_pkg::RD_REM_LO_HI: nxt_st.rdata = st_ff.rem_lo_hi;
				tas_pkg::RD_REMOTE_LO: nxt_st.rdata = {st_ff.remote_temp[1:0], 6'h00};
				tas_pkg::RW_CORR_HI: nxt_st.rdata = st_ff.corr_hi;
				tas_pkg::RW_CORR_LO: nxt_st.rdata = st_ff.corr_lo;
				tas_pkg::RW_REM_UP_LO: nxt_st.rdata = st_ff.rem_up_lo;
				tas_pkg::RW_REM_LO_LO: nxt_st.rdata = st_ff.rem_lo_lo;
				tas_pkg::RW_REM_OT: nxt_st.rdata = st_ff.rem_ot;
				tas_pkg::RW_LOC_OT: nxt_st.rdata = st_ff.loc_ot;
				tas_pkg::RW_HYST: nxt_st.rdata = st_ff.hyst;
				tas_pkg::RW_FAULT_CNT: nxt_st.rdata = st_ff.fcnt;
				tas_pkg::RD_MAKER: nxt_st.rdata = tas_pkg::MAKER_ID;
				default: nxt_st.rdata = tas_pkg::RST_ZERO;
			endcase
			if (i_reg_addr == tas_pkg::RD_FLAGS) begin
				for (int b = 0; b < 5; b++) begin
					if (!cause[b]) begin
						nxt_st.flags[tas_pkg::FLAG_OPEN + b] = 1'b0;
					end
				end
			end
		end
		// Status has no write address, so writes never reach the flags.
		if (i_reg_wr) begin
			case (i_reg_addr)
				tas_pkg::WR_SETUP: nxt_st.setup = i_reg_wdata;
				tas_pkg::WR_RATE: nxt_st.rate = i_reg_wdata;
				tas_pkg::WR_LOC_UP: nxt_st.loc_up = i_reg_wdata;
				tas_pkg::WR_LOC_LO: nxt_st.loc_lo = i_reg_wdata;
				tas_pkg::WR_REM_UP_HI: nxt_st.rem_up_hi = i_reg_wdata;
				tas_pkg::WR_REM_LO_HI: nxt_st.rem_lo_hi = i_reg_wdata;
				tas_pkg::WR_ONE_SHOT: nxt_st.conv_start = 1'b1;
				tas_pkg::RW_CORR_HI: nxt_st.corr_hi = i_reg_wdata;
				tas_pkg::RW_CORR_LO: nxt_st.corr_lo = {i_reg_wdata[7:6], 6'h00};
				tas_pkg::RW_REM_UP_LO: nxt_st.rem_up_lo = i_reg_wdata;
				tas_pkg::RW_REM_LO_LO: nxt_st.rem_lo_lo = i_reg_wdata;
				tas_pkg::RW_REM_OT: nxt_st.rem_ot = i_reg_wdata;
				tas_pkg::RW_LOC_OT: nxt_st.loc_ot = i_reg_wdata;
				tas_pkg::RW_HYST: nxt_st.hyst = i_reg_wdata;
				tas_pkg::RW_FAULT_CNT: nxt_st.fcnt = i_reg_wdata;
				default: nxt_st.rem_ot = st_ff.rem_ot;
			endcase
		end
		if (i_conv_done) begin
			nxt_st.local_temp = i_local_raw;
			nxt_st.remote_temp = rem_adj;
			// Over-temperature trips with hysteresis; each channel releases on its own.
			if (i_local_raw > st_ff.loc_ot) begin
				nxt_st.loc_ot_trip = 1'b1;
			end else if (i_local_raw <= loc_rel) begin
				nxt_st.loc_ot_trip = 1'b0;
			end
			if (rem_adj[9:2] > st_ff.rem_ot) begin
				nxt_st.rem_ot_trip = 1'b1;
			end else if (rem_adj[9:2] <= rem_rel) begin
				nxt_st.rem_ot_trip = 1'b0;
			end
			if (i_local_raw > st_ff.loc_up) begin
				nxt_st.loc_up_trip = 1'b1;
			end else if (i_local_raw <= (st_ff.loc_up - st_ff.hyst)) begin
				nxt_st.loc_up_trip = 1'b0;
			end
			if (rem_adj[9:2] > st_ff.rem_up_hi) begin
				nxt_st.rem_up_trip = 1'b1;
			end else if (rem_adj[9:2] <= (st_ff.rem_up_hi - st_ff.hyst)) begin
				nxt_st.rem_up_trip = 1'b0;
			end
		end
		nxt_st.flags[tas_pkg::FLAG_LOC_OT] = nxt_st.loc_ot_trip;
		nxt_st.flags[tas_pkg::FLAG_REM_OT] = nxt_st.rem_ot_trip;
		if (comp_mode) begin
			nxt_st.flags[tas_pkg::FLAG_LOC_UP] = nxt_st.loc_up_trip;
			nxt_st.flags[tas_pkg::FLAG_REM_UP] = nxt_st.rem_up_trip;
			nxt_st.flags[tas_pkg::FLAG_LOC_LO] = 1'b0;
			nxt_st.flags[tas_pkg::FLAG_REM_LO] = 1'b0;
		end else begin
			// Setting after the read clear lets a same-cycle event win.
			if (fire[0]) nxt_st.flags[tas_pkg::FLAG_LOC_UP] = 1'b1;
			if (fire[1]) nxt_st.flags[tas_pkg::FLAG_LOC_LO] = 1'b1;
			if (fire[2]) nxt_st.flags[tas_pkg::FLAG_REM_UP] = 1'b1;
			if (fire[3]) nxt_st.flags[tas_pkg::FLAG_REM_LO] = 1'b1;
		end
		if (open_s2_ff) begin
			nxt_st.flags[tas_pkg::FLAG_OPEN] = 1'b1;
		end
		// The latch follows the flags into set, but only alert servicing or comparator mode releases it.
		if (!comp_mode && (|st_ff.flags[6:2])) begin
			nxt_st.alert_latch = 1'b1;
		end else if (i_ara_read && st_ff.alert_latch && !(|st_ff.flags[6:2])
			&& !(|cause)) begin
			nxt_st.alert_latch = 1'b0;
		end
		if (comp_mode) begin
			nxt_st.alert_latch = 1'b0;
			nxt_st.alert_oe = st_ff.flags[tas_pkg::FLAG_LOC_UP]
				| st_ff.flags[tas_pkg::FLAG_REM_UP];
		end else begin
			nxt_st.alert_oe = nxt_st.alert_latch && !st_ff.setup[tas_pkg::SETUP_MASK_BIT];
		end
		nxt_st.ara_ans = st_ff.alert_oe && !comp_mode;
		nxt_st.ot_n = !(nxt_st.flags[tas_pkg::FLAG_LOC_OT]
			| nxt_st.flags[tas_pkg::FLAG_REM_OT]);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			st_ff <= '0;
			st_ff.setup <= tas_pkg::RST_SETUP;
			st_ff.rate <= tas_pkg::RST_RATE;
			st_ff.loc_up <= tas_pkg::RST_UPPER;
			st_ff.rem_up_hi <= tas_pkg::RST_UPPER;
			st_ff.corr_hi <= tas_pkg::RST_CORR;
			st_ff.corr_lo <= tas_pkg::RST_CORR;
			st_ff.rem_ot <= tas_pkg::RST_OT;
			st_ff.loc_ot <= tas_pkg::RST_OT;
			st_ff.hyst <= tas_pkg::RST_HYST;
			st_ff.fcnt <= tas_pkg::RST_FAULT_CNT;
			st_ff.ot_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// The open-circuit detector sits in the analog domain, so it is synchronised first.
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			open_s1_ff <= 1'b0;
			open_s2_ff <= 1'b0;
		end else begin
			open_s1_ff <= i_remote_open;
			open_s2_ff <= open_s1_ff;
		end
	end

	assign o_reg_rdata = st_ff.rdata;
	assign o_conv_start = st_ff.conv_start;
	assign o_standby = st_ff.setup[tas_pkg::SETUP_STANDBY_BIT];
	assign o_rate_code = st_ff.rate[3:0];
	assign o_ext_range = st_ff.setup[2];
	assign o_alert_n_oe = st_ff.alert_oe;
	assign o_overtemp_comparator_out_n = st_ff.ot_n;
	assign o_ara_answer = st_ff.ara_ans;
	assign o_bus_abort = wd_abort;
endmodule
`default_nettype wire

// [common/tas_pkg.sv]
/*
 * Package of the thermal alarm status register block: register addresses, field positions,
 * power-on values and timing counts.
 * Assumes a 250 MHz system clock and a byte-wide register port fed by a separate bus engine.
 */
package tas_pkg;
	localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] RD_REMOTE_HI = 8'h01;
	localparam logic [7:0] RD_FLAGS = 8'h02;
	localparam logic [7:0] RD_SETUP = 8'h03;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_LOC_UP = 8'h05;
	localparam logic [7:0] RD_LOC_LO = 8'h06;
	localparam logic [7:0] RD_REM_UP_HI = 8'h07;
	localparam logic [7:0] RD_REM_LO_HI = 8'h08;
	localparam logic [7:0] WR_SETUP = 8'h09;
	localparam logic [7:0] WR_RATE = 8'h0A;
	localparam logic [7:0] WR_LOC_UP = 8'h0B;
	localparam logic [7:0] WR_LOC_LO = 8'h0C;
	localparam logic [7:0] WR_REM_UP_HI = 8'h0D;
	localparam logic [7:0] WR_REM_LO_HI = 8'h0E;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
	localparam logic [7:0] RD_REMOTE_LO = 8'h10;
	localparam logic [7:0] RW_CORR_HI = 8'h11;
	localparam logic [7:0] RW_CORR_LO = 8'h12;
	localparam logic [7:0] RW_REM_UP_LO = 8'h13;
	localparam logic [7:0] RW_REM_LO_LO = 8'h14;
	localparam logic [7:0] RW_REM_OT = 8'h19;
	localparam logic [7:0] RW_LOC_OT = 8'h20;
	localparam logic [7:0] RW_HYST = 8'h21;
	localparam logic [7:0] RW_FAULT_CNT = 8'h22;
	localparam logic [7:0] RD_MAKER = 8'hFE;

	localparam logic [7:0] RST_SETUP = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h08;
	localparam logic [7:0] RST_UPPER = 8'h55;
	localparam logic [7:0] RST_LOWER = 8'h00;
	localparam logic [7:0] RST_OT = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0A;
	localparam logic [7:0] RST_FAULT_CNT = 8'h01;
	localparam logic [7:0] RST_CORR = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Identification value is arbitrary.
	localparam logic [7:0] MAKER_ID = 8'h5A;

	localparam int SETUP_MASK_BIT = 7;
	localparam int SETUP_STANDBY_BIT = 6;
	localparam int SETUP_PIN_MODE_BIT = 5;
	localparam int FLAG_BUSY = 7;
	localparam int FLAG_LOC_UP = 6;
	localparam int FLAG_LOC_LO = 5;
	localparam int FLAG_REM_UP = 4;
	localparam int FLAG_REM_LO = 3;
	localparam int FLAG_OPEN = 2;
	localparam int FLAG_REM_OT = 1;
	localparam int FLAG_LOC_OT = 0;
	localparam int FCNT_TIMEOUT_BIT = 7;
	localparam int FCNT_LSB = 1;

	localparam int TIMEOUT_MS = 25;
	localparam int CLK_MHZ = 250;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
endpackage

// [hw/tas_run_filter.sv]
/*
 * Counter of consecutive out-of-limit measurements for one condition.
 * Assumes i_sample pulses once per finished measurement with i_out valid in that cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tas_run_filter (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_sample,
	input wire logic i_out,
	input wire logic [2:0] i_need_code,
	output logic o_fire
);
	typedef struct packed {
		logic [2:0] run;
	} tas_rf_t;
	tas_rf_t st_ff;
	tas_rf_t nxt_st;
	logic [2:0] need;

	always_comb begin
		case (i_need_code)
			3'h1: need = 3'h2;
			3'h3: need = 3'h3;
			3'h7: need = 3'h4;
			default: need = 3'h1;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		if (i_sample) begin
			if (!i_out) begin
				nxt_st.run = 3'h0;
			end else if (st_ff.run < need) begin
				nxt_st.run = st_ff.run + 3'h1;
			end
		end
	end

	// A run longer than the target keeps firing, so a standing fault stays reported.
	assign o_fire = i_sample && i_out && ((st_ff.run + 3'h1) >= need);

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// [hw/tas_bus_watchdog.sv]
/*
 * Idle timer of the serial interface that requests a transaction abort.
 * Assumes i_active pulses on every bus event and i_in_txn is high inside a transaction.
 */
`timescale 1ns/1ps
`default_nettype none
module tas_bus_watchdog #(
	parameter int TIMEOUT_CYCLES = tas_pkg::TIMEOUT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_enable,
	input wire logic i_in_txn,
	input wire logic i_active,
	output logic o_abort
);
	typedef struct packed {
		logic [23:0] cnt;
		logic abort;
	} tas_wd_t;
	tas_wd_t st_ff;
	tas_wd_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.abort = 1'b0;
		if (!i_enable || !i_in_txn || i_active) begin
			nxt_st.cnt = 24'h00_0000;
		end else if (st_ff.cnt == 24'(TIMEOUT_CYCLES - 1)) begin
			nxt_st.abort = 1'b1;
			nxt_st.cnt = 24'h00_0000;
		end else begin
			nxt_st.cnt = st_ff.cnt + 24'h00_0001;
		end
	end

	assign o_abort = st_ff.abort;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// [tb/tas_regs_assertions.sv]
/* Port checker for the thermal alarm status register block.
   Assumes one clock, a synchronous active-low reset and a bind to every tas_regs. */
`timescale 1ns/1ps
`default_nettype none
module tas_regs_assertions #(
	parameter int TIMEOUT_CYCLES = tas_pkg::TIMEOUT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_ara_read,
	input wire logic i_bus_in_txn,
	input wire logic i_bus_active,
	input wire logic o_bus_abort,
	input wire logic i_conv_busy,
	input wire logic i_conv_done,
	input wire logic [7:0] i_local_raw,
	input wire logic [9:0] i_remote_raw,
	input wire logic i_remote_open,
	input wire logic o_conv_start,
	input wire logic o_standby,
	input wire logic [3:0] o_rate_code,
	input wire logic o_ext_range,
	input wire logic o_ara_answer,
	input wire logic o_alert_n_oe,
	input wire logic o_overtemp_comparator_out_n
);
	logic [7:0] setup_ff;
	logic to_en_ff;
	int idle_ff;
	logic rd_st;
	logic wr_st;
	logic live;
	assign rd_st = i_reg_rd && i_reg_addr == tas_pkg::RD_FLAGS;
	assign wr_st = i_reg_wr && i_reg_addr == tas_pkg::WR_SETUP;
	// The latch only reaches the pin in alert mode with the mask clear.
	assign live = !setup_ff[tas_pkg::SETUP_MASK_BIT] && !setup_ff[tas_pkg::SETUP_PIN_MODE_BIT];
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			setup_ff <= 8'h00;
			to_en_ff <= 1'b0;
			idle_ff <= 0;
		end else begin
			if (wr_st) begin
				setup_ff <= i_reg_wdata;
			end
			if (i_reg_wr && i_reg_addr == tas_pkg::RW_FAULT_CNT) begin
				to_en_ff <= i_reg_wdata[7];
			end
			idle_ff <= (i_bus_in_txn && !i_bus_active) ? idle_ff + 1 : 0;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	AST_START_PULSE: assert property (
		i_reg_wr && i_reg_addr == 8'h0F |=> o_conv_start)
		else $error("one-shot write gave no start");
	AST_START_CAUSE: assert property (
		o_conv_start |-> $past(i_reg_wr && i_reg_addr == 8'h0F))
		else $error("start without one-shot write");
	AST_BUSY_BIT: assert property (
		rd_st && $stable(i_conv_busy) && i_conv_busy == $past(i_conv_busy, 2)
		|=> o_reg_rdata[7] == $past(i_conv_busy))
		else $error("busy bit differs from converter");
	AST_ALERT_SET: assert property (
		live && rd_st ##1 o_reg_rdata[6:2] != 5'h00 |-> ##[0:1] o_alert_n_oe)
		else $error("flags set but alert pin idle");
	AST_ALERT_HOLD: assert property (
		live && o_alert_n_oe && !i_ara_read && !$past(i_ara_read) && !wr_st
		|=> o_alert_n_oe)
		else $error("alert latch cleared without response read");
	AST_OT_FLAGS: assert property (
		rd_st && !i_conv_done && !$past(i_conv_done) && !$past(i_conv_done, 2)
		##1 o_reg_rdata[1:0] != 2'b00 |-> ##[0:1] !o_overtemp_comparator_out_n)
		else $error("trip flag set but comparator output high");
	AST_ABORT_CAUSE: assert property (
		o_bus_abort |-> to_en_ff && idle_ff >= TIMEOUT_CYCLES - 2)
		else $error("abort without enabled idle timeout");
	AST_ABORT_PULSE: assert property (o_bus_abort |=> !o_bus_abort)
		else $error("abort longer than one cycle");
	AST_SETUP_FIELDS: assert property (
		wr_st |=> o_standby == $past(i_reg_wdata[6])
		&& o_ext_range == $past(i_reg_wdata[2]))
		else $error("setup fields not delivered");
endmodule
bind tas_regs tas_regs_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.*);
`default_nettype wire

// [tb/tas_host_model.sv]
/* Bus host and converter model facing tas_regs.
   Assumes the register strobe contract of tas_regs; the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module tas_host_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_conv_start,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_ara,
	output logic o_txn,
	output logic o_active,
	output logic o_busy,
	output logic o_done,
	output logic [7:0] o_local,
	output logic [9:0] o_remote
);
	logic [7:0] loc_val = 8'h30;
	logic [9:0] rem_val = 10'h0C0;
	int cnt = 0;
	initial begin
		{o_wr, o_rd, o_ara, o_txn, o_active, o_busy, o_done} = 7'h00;
		{o_addr, o_wdata, o_local, o_remote} = 34'h0_0000_0000;
	end
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge i_sys_clk);
		o_wr <= w;
		o_rd <= !w;
		o_active <= 1'b1;
		o_addr <= a;
		o_wdata <= v;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_active <= 1'b0;
		// Released lines show the inverse so a stale value never passes as fresh.
		o_addr <= ~a;
		o_wdata <= ~v;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		access(1'b1, a, v);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		access(1'b0, a, 8'h00);
		@(negedge i_sys_clk);
		v = i_rdata;
	endtask
	task automatic ara();
		@(posedge i_sys_clk);
		o_ara <= 1'b1;
		@(posedge i_sys_clk);
		o_ara <= 1'b0;
	endtask
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		o_local <= ~o_local;
		o_remote <= ~o_remote;
		if (i_conv_start) begin
			cnt <= 10;
			o_busy <= 1'b1;
		end else if (cnt == 1) begin
			cnt <= 0;
			o_busy <= 1'b0;
			o_done <= 1'b1;
			o_local <= loc_val;
			o_remote <= rem_val;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// [tb/test_thermal_alarm_status_regs.sv]
/* Self-checking bench of tas_regs driven through the host model.
   Assumes tas_pkg, tas_regs, the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_thermal_alarm_status_regs;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_remote_open = 1'b0;
	logic i_reg_wr, i_reg_rd, i_ara_read, i_bus_in_txn, i_bus_active, i_conv_busy, i_conv_done;
	logic [7:0] i_reg_addr, i_reg_wdata, i_local_raw, o_reg_rdata, d;
	logic [9:0] i_remote_raw;
	logic [3:0] o_rate_code;
	logic o_bus_abort, o_conv_start, o_standby, o_ext_range, o_ara_answer, o_alert_n_oe;
	logic o_overtemp_comparator_out_n;
	int n_errors = 0;
	int samples_checked = 0;
	int k;
	// Columns: write address, read address, write data, expected read data.
	logic [31:0] rows [0:29] = '{32'hFF03_0000, 32'hFF04_0008, 32'hFF05_0055, 32'hFF06_0000,
		32'hFF07_0055, 32'hFF08_0000, 32'hFF00_0000, 32'hFF01_0000, 32'hFF10_0000,
		32'hFF11_0000, 32'hFF12_0000, 32'hFF13_0000, 32'hFF14_0000, 32'hFF19_0055,
		32'hFF20_0055, 32'hFF21_000A, 32'hFF22_0001, 32'hFFFE_005A, 32'hFF30_0000,
		32'h0202_FF00, 32'h0505_7755, 32'h0B05_5A5A, 32'h0C06_1111, 32'h0D07_6060,
		32'h0E08_0505, 32'h0A04_0505, 32'h1111_FCFC, 32'h1212_C0C0, 32'h2020_7F7F,
		32'h1919_7F7F};
	always #2 i_sys_clk = ~i_sys_clk;
	tas_regs #(.TIMEOUT_CYCLES(50)) dut_u (.*);
	tas_host_model host_u (.i_sys_clk(i_sys_clk), .i_rdata(o_reg_rdata),
		.i_conv_start(o_conv_start), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
		.o_wdata(i_reg_wdata), .o_ara(i_ara_read), .o_txn(i_bus_in_txn),
		.o_active(i_bus_active), .o_busy(i_conv_busy), .o_done(i_conv_done),
		.o_local(i_local_raw), .o_remote(i_remote_raw));
	task automatic summarize();
		$display("TB: %0d checks, %0d mismatches", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_u.rd(a, v);
		chk(v, exp);
	endtask
	task automatic pins(input logic oe, input logic ot_n);
		chk({6'h00, o_alert_n_oe, o_overtemp_comparator_out_n}, {6'h00, oe, ot_n});
	endtask
	task automatic conv(input logic [7:0] l, input logic [9:0] r);
		int n;
		host_u.loc_val = l;
		host_u.rem_val = r;
		host_u.wr(8'h0F, 8'hAB);
		for (n = 0; n < 40 && i_conv_done !== 1'b1; n++) begin
			@(negedge i_sys_clk);
		end
		if (n == 40) begin
			n_errors++;
			summarize();
		end
		repeat (4) @(negedge i_sys_clk);
	endtask
	task automatic ara_clear();
		host_u.ara();
		repeat (3) @(negedge i_sys_clk);
		pins(1'b0, 1'b1);
	endtask
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		for (k = 0; k < 30; k++) begin
			host_u.wr(rows[k][31:24], rows[k][15:8]);
			rdchk(rows[k][23:16], rows[k][7:0]);
		end
		$display("TB: register table done");
		// The remote offset is now -3.25 degrees, so remote results sit 0x0D quarters lower.
		conv(8'h5A, 10'h18C);
		rdchk(8'h02, 8'h00);
		conv(8'h5B, 10'h190);
		rdchk(8'h02, 8'h50);
		pins(1'b1, 1'b1);
		rdchk(8'h01, 8'h60);
		rdchk(8'h10, 8'hC0);
		conv(8'h11, 10'h020);
		rdchk(8'h02, 8'h78);
		rdchk(8'h02, 8'h28);
		conv(8'h30, 10'h0C0);
		rdchk(8'h02, 8'h28);
		rdchk(8'h02, 8'h00);
		chk({7'h00, o_ara_answer}, 8'h01);
		pins(1'b1, 1'b1);
		ara_clear();
		$display("TB: alert flags done");
		for (k = 0; k < 4; k++) begin
			host_u.wr(8'h22, {4'h0, 3'((1 << k) - 1), 1'b0});
			repeat (k) conv(8'h5B, 10'h0C0);
			conv(8'h30, 10'h0C0);
			repeat (k) conv(8'h5B, 10'h0C0);
			rdchk(8'h02, 8'h00);
			conv(8'h5B, 10'h0C0);
			conv(8'h30, 10'h0C0);
			rdchk(8'h02, 8'h40);
			rdchk(8'h02, 8'h00);
			ara_clear();
		end
		host_u.wr(8'h22, 8'h00);
		$display("TB: fault filter done");
		host_u.wr(8'h09, 8'h20);
		conv(8'h5B, 10'h0C0);
		pins(1'b1, 1'b1);
		conv(8'h55, 10'h0C0);
		pins(1'b1, 1'b1);
		conv(8'h50, 10'h0C0);
		pins(1'b0, 1'b1);
		conv(8'h11, 10'h0C0);
		pins(1'b0, 1'b1);
		conv(8'h30, 10'h0C0);
		rdchk(8'h02, 8'h00);
		@(posedge i_sys_clk);
		i_remote_open <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		i_remote_open <= 1'b0;
		repeat (6) @(negedge i_sys_clk);
		rdchk(8'h02, 8'h04);
		pins(1'b0, 1'b1);
		rdchk(8'h02, 8'h00);
		host_u.wr(8'h09, 8'h00);
		host_u.ara();
		$display("TB: second comparator done");
		host_u.wr(8'h20, 8'h40);
		conv(8'h41, 10'h0C0);
		pins(1'b0, 1'b0);
		rdchk(8'h02, 8'h01);
		conv(8'h3A, 10'h0C0);
		pins(1'b0, 1'b0);
		conv(8'h36, 10'h0C0);
		pins(1'b0, 1'b1);
		rdchk(8'h02, 8'h00);
		host_u.wr(8'h19, 8'h40);
		host_u.wr(8'h0F, 8'h00);
		repeat (4) @(posedge i_sys_clk);
		host_u.rd(8'h02, d);
		chk(d & 8'h80, 8'h80);
		repeat (12) @(negedge i_sys_clk);
		conv(8'h30, 10'h118);
		rdchk(8'h02, 8'h02);
		conv(8'h30, 10'h0C0);
		pins(1'b0, 1'b1);
		$display("TB: over-temperature done");
		@(posedge i_sys_clk);
		host_u.o_txn <= 1'b1;
		d = 8'h00;
		repeat (80) begin
			@(negedge i_sys_clk);
			d = d + {7'h00, o_bus_abort};
		end
		chk(d, 8'h00);
		host_u.wr(8'h22, 8'h81);
		for (k = 0; k < 200 && o_bus_abort !== 1'b1; k++) begin
			@(negedge i_sys_clk);
		end
		chk(8'(k > 44 && k < 60), 8'h01);
		if (k == 200) begin
			summarize();
		end
		@(posedge i_sys_clk);
		host_u.o_txn <= 1'b0;
		$display("TB: bus timeout done");
		i_resetn <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		rdchk(8'h05, 8'h55);
		rdchk(8'h11, 8'h00);
		rdchk(8'h22, 8'h01);
		pins(1'b0, 1'b1);
		$display("TB: second reset done");
		summarize();
	end
endmodule
`default_nettype wire
